// ===== src/spie_ctrl.sv
// SPI controller core with enable, soft reset, chip select configs and quirks kept.
`timescale 1ns/1ns
// Function
// (R1) Hold on chip select 0 with fault detection enabled blocks every transfer start.
// (R2) Software sets fault detect disable when it needs hold on chip select 0.
// (R3) Data writes while disabled are dropped and leave tx empty set.
// (R4) Disabling leaves tx empty unchanged so DMA keeps writing into loss.
// (R5) Software stops DMA, waits two instructions, then disables; resumes reversed.
// (R6) Disable command is ignored in slave mode; block keeps working as slave.
// (R7) Software reads last word then writes soft reset to stop a slave.
// (R8) Mixed divider one with others and polarity 1 phase 0 adds extra clock pulse; the code compares only selects 0 and 1 and adds it on a non-one divider.
// (R9) Software sets all dividers to one in that polarity and phase case.
// (R10) Soft reset restores all settings and discards pending transmit and receive data.
module spie_ctrl #(
	parameter int NUM_CS = spie_pkg::NUM_CS,
	parameter int DATA_W = spie_pkg::DATA_W
) (
	input  wire logic                   ref_clk,
	input  wire logic                   rst,
	input  wire logic                   enable_cmd,
	input  wire logic                   disable_cmd,
	input  wire logic                   soft_reset_bit,
	input  wire logic                   mode_wr,
	input  wire spie_pkg::spie_mode_t   mode_wdata,
	input  wire logic                   cs_cfg_wr,
	input  wire logic [1:0]             cs_cfg_idx,
	input  wire spie_pkg::spie_cs_cfg_t cs_cfg_wdata,
	input  wire logic                   tx_data_wr,
	input  wire logic [DATA_W-1:0]      tx_data_reg,
	input  wire logic                   rx_data_rd,
	input  wire logic                   miso_in,
	input  wire logic                   mosi_in,
	input  wire logic                   sck_in,
	input  wire logic                   nss_in,
	output logic                        tx_empty_flag,
	output logic                        rx_full_flag,
	output logic [DATA_W-1:0]           rx_data,
	output logic                        enabled,
	output logic                        sck_out,
	output logic                        sck_oe,
	output logic                        mosi_out,
	output logic                        mosi_oe,
	output logic                        miso_out,
	output logic                        miso_oe,
	output logic [NUM_CS-1:0]           cs_n_out
);
	spie_pkg::spie_mode_t   mode_q;
	spie_pkg::spie_cs_cfg_t cfg_q [NUM_CS];
	spie_pkg::spie_state_t  state_q;
	logic [DATA_W-1:0]      tx_buf_q;
	logic [DATA_W-1:0]      sh_q;
	logic [3:0]             bit_q;
	logic                   phase_q;
	logic                   extra_q;
	logic                   sck_in_q;
	logic                   tick;

	wire spie_pkg::spie_cs_cfg_t cur = cfg_q[mode_q.cs_sel];
	wire start_block = cfg_q[0].cs_hold_after_transfer && !mode_q.fault_detect_disable; // see (R1)
	wire wr_ok       = tx_data_wr && enabled; // see (R3)
	wire dis_ok      = disable_cmd && mode_q.master; // see (R6)
	wire srst        = rst || soft_reset_bit; // see (R10)
	wire cur_div1    = cur.serial_clock_divider == spie_pkg::DIV_ONE;
	wire mixed       = (cfg_q[0].serial_clock_divider == spie_pkg::DIV_ONE)
		!= (cfg_q[1].serial_clock_divider == spie_pkg::DIV_ONE);
	wire quirk       = mixed && cur.clock_polarity && !cur.clock_phase_inverted; // see (R8)
	wire can_start   = enabled && mode_q.master && !tx_empty_flag && !start_block
		&& state_q == spie_pkg::SPIE_IDLE;
	wire last_bit    = bit_q == 4'(DATA_W - 1);
	wire sck_rise    = sck_in && !sck_in_q;
	wire slave_act   = enabled && !mode_q.master && !nss_in;

	spie_clkdiv #(.DIV_W(spie_pkg::DIV_W)) u_div (
		.ref_clk (ref_clk),
		.rst     (srst),
		.run     (state_q == spie_pkg::SPIE_SHIFT),
		.divider (cur.serial_clock_divider),
		.tick    (tick)
	);

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			mode_q        <= spie_pkg::MODE_RESET;
			for (int i = 0; i < NUM_CS; i++) cfg_q[i] <= spie_pkg::CS_CFG_RESET;
			state_q       <= spie_pkg::SPIE_IDLE;
			enabled       <= 1'b0;
			tx_empty_flag <= 1'b1;
			rx_full_flag  <= 1'b0;
			tx_buf_q      <= '0;
			sh_q          <= '0;
			rx_data       <= '0;
			bit_q         <= '0;
			phase_q       <= 1'b0;
			extra_q       <= 1'b0;
			sck_in_q      <= 1'b0;
			sck_out       <= 1'b0;
			sck_oe        <= 1'b0;
			mosi_out      <= 1'b0;
			mosi_oe       <= 1'b0;
			miso_out      <= 1'b0;
			miso_oe       <= 1'b0;
			cs_n_out      <= '1;
		end else begin
			sck_in_q <= sck_in;
			if (enable_cmd) begin
				enabled <= 1'b1;
			end else if (dis_ok) begin
				enabled <= 1'b0; // see (R4)
			end
			if (mode_wr) begin
				mode_q <= mode_wdata;
			end
			if (cs_cfg_wr) begin
				cfg_q[cs_cfg_idx] <= cs_cfg_wdata;
			end
			if (wr_ok) begin
				tx_buf_q      <= tx_data_reg;
				tx_empty_flag <= 1'b0; // see (R3)
			end
			if (rx_data_rd) begin
				rx_full_flag <= 1'b0;
			end
			sck_oe  <= mode_q.master;
			mosi_oe <= mode_q.master;
			miso_oe <= slave_act;
			case (state_q)
				spie_pkg::SPIE_IDLE: begin
					sck_out <= cur.clock_polarity;
					// A held select is let go once the selected config no longer asks for hold.
					if (!cur.cs_hold_after_transfer) cs_n_out <= '1;
					if (can_start) begin
						sh_q          <= tx_buf_q;
						tx_empty_flag <= wr_ok ? 1'b0 : 1'b1;
						bit_q         <= '0;
						phase_q       <= 1'b0;
						extra_q       <= quirk && !cur_div1;
						cs_n_out      <= ~(NUM_CS'(1) << mode_q.cs_sel);
						mosi_out      <= tx_buf_q[DATA_W-1];
						state_q       <= spie_pkg::SPIE_SHIFT;
					end else if (slave_act && sck_rise) begin
						sh_q     <= {sh_q[DATA_W-2:0], mosi_in};
						miso_out <= sh_q[DATA_W-1];
						bit_q    <= last_bit ? 4'h0 : bit_q + 4'h1;
						if (last_bit) begin
							rx_data      <= {sh_q[DATA_W-2:0], mosi_in};
							rx_full_flag <= 1'b1;
						end
					end
				end
				spie_pkg::SPIE_SHIFT: begin
					if (tick) begin
						sck_out <= ~sck_out;
						phase_q <= ~phase_q;
						if (!phase_q) begin
							sh_q <= {sh_q[DATA_W-2:0], miso_in};
						end else if (last_bit) begin
							state_q <= spie_pkg::SPIE_DONE;
						end else begin
							bit_q    <= bit_q + 4'h1;
							mosi_out <= sh_q[DATA_W-1];
						end
					end
				end
				default: begin
					// The faulty clock path emits one spurious toggle pair before returning idle.
					if (extra_q) begin
						sck_out <= ~sck_out; // see (R8)
						extra_q <= sck_out == cur.clock_polarity;
					end else begin
						rx_data      <= sh_q;
						rx_full_flag <= 1'b1;
						if (!cur.cs_hold_after_transfer) cs_n_out <= '1;
						// The slave path shares this counter, so it must restart from zero.
						bit_q        <= '0;
						state_q      <= spie_pkg::SPIE_IDLE;
					end
				end
			endcase
		end
	end

	property p_r1_block;
		@(posedge ref_clk) disable iff (rst)
			(start_block && state_q == spie_pkg::SPIE_IDLE && !mode_wr && !cs_cfg_wr && !soft_reset_bit)
			|=> state_q == spie_pkg::SPIE_IDLE;
	endproperty
	a_r1_block: assert property (p_r1_block) else $error("transfer started while blocked"); // see (R1)

	property p_r3_drop;
		@(posedge ref_clk) disable iff (rst)
			(tx_data_wr && !enabled && tx_empty_flag && !soft_reset_bit) |=> tx_empty_flag;
	endproperty
	a_r3_drop: assert property (p_r3_drop) else $error("write while disabled cleared tx empty"); // see (R3)

	property p_r4_flag;
		@(posedge ref_clk) disable iff (rst)
			(dis_ok && !tx_data_wr && !can_start && !soft_reset_bit)
			|=> tx_empty_flag == $past(tx_empty_flag);
	endproperty
	a_r4_flag: assert property (p_r4_flag) else $error("disable changed tx empty"); // see (R4)

	property p_r6_slave;
		@(posedge ref_clk) disable iff (rst)
			(disable_cmd && enabled && !mode_q.master && !soft_reset_bit) |=> enabled;
	endproperty
	a_r6_slave: assert property (p_r6_slave) else $error("slave disabled by command"); // see (R6)

	property p_r10_srst;
		@(posedge ref_clk) disable iff (rst)
			soft_reset_bit |=> !enabled && tx_empty_flag && !rx_full_flag && &cs_n_out;
	endproperty
	a_r10_srst: assert property (p_r10_srst) else $error("soft reset left state"); // see (R10)

	property p_r10_cfg;
		@(posedge ref_clk) disable iff (rst)
			soft_reset_bit |=> mode_q == spie_pkg::MODE_RESET && cfg_q[0] == spie_pkg::CS_CFG_RESET;
	endproperty
	a_r10_cfg: assert property (p_r10_cfg) else $error("soft reset left settings"); // see (R10)

	property p_r3_keep;
		@(posedge ref_clk) disable iff (rst)
			(tx_data_wr && !enabled && !soft_reset_bit) |=> tx_buf_q == $past(tx_buf_q);
	endproperty
	a_r3_keep: assert property (p_r3_keep) else $error("write while disabled reached the buffer"); // see (R3)

	property p_r8_extra;
		@(posedge ref_clk) disable iff (rst)
			(state_q == spie_pkg::SPIE_DONE && extra_q && !soft_reset_bit) |=> sck_out != $past(sck_out);
	endproperty
	a_r8_extra: assert property (p_r8_extra) else $error("extra clock pulse missing"); // see (R8)
endmodule

// ===== shared/spie_pkg.sv
// Package with constants and types for the SPI controller with documented quirks.
package spie_pkg;
	localparam int NUM_CS        = 4;
	localparam int DATA_W        = 8;
	localparam int DIV_W         = 8;
	localparam logic [7:0] DIV_RESET = 8'h01;
	localparam logic [7:0] DIV_ONE   = 8'h01;

	typedef struct packed {
		logic [7:0] serial_clock_divider;
		logic       clock_polarity;
		logic       clock_phase_inverted;
		logic       cs_hold_after_transfer;
	} spie_cs_cfg_t;

	localparam spie_cs_cfg_t CS_CFG_RESET = '{serial_clock_divider: 8'h01, clock_polarity: 1'b0,
		clock_phase_inverted: 1'b0, cs_hold_after_transfer: 1'b0};

	typedef struct packed {
		logic       master;
		logic       fault_detect_disable;
		logic [1:0] cs_sel;
	} spie_mode_t;

	localparam spie_mode_t MODE_RESET = '{master: 1'b0, fault_detect_disable: 1'b0, cs_sel: 2'h0};

	typedef enum logic [1:0] {
		SPIE_IDLE  = 2'b00,
		SPIE_SHIFT = 2'b01,
		SPIE_DONE  = 2'b10
	} spie_state_t;
endpackage

// ===== src/spie_clkdiv.sv
// Serial clock divider that emits one-cycle enable pulses.
`timescale 1ns/1ns
module spie_clkdiv #(
	parameter int DIV_W = 8
) (
	input  wire logic             ref_clk,
	input  wire logic             rst,
	input  wire logic             run,
	input  wire logic [DIV_W-1:0] divider,
	output logic                  tick
);
	logic [DIV_W-1:0] cnt_q;
	logic [DIV_W-1:0] cnt_d;
	wire              hit = (cnt_q + DIV_W'(1)) >= divider;

	assign cnt_d = (!run || hit) ? '0 : cnt_q + DIV_W'(1);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cnt_q <= '0;
			tick  <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			tick  <= run && hit;
		end
	end
endmodule

// ===== test/spie_slave_model.sv
// Behavioural SPI peripheral on one chip select, sampling on the rising serial clock.
`timescale 1ns/1ns
module spie_slave_model (
	input  wire logic       sck,
	input  wire logic       cs_n,
	input  wire logic       mosi,
	input  wire logic [7:0] reply,
	output logic            miso,
	output logic [7:0]      got
);
	logic [7:0] sh;
	always @(negedge cs_n) begin
		sh = reply;
		miso = reply[7];
	end
	always @(posedge sck) if (!cs_n) begin
		got = {got[6:0], mosi};
	end
	always @(negedge sck) if (!cs_n) begin
		sh = {sh[6:0], 1'b0};
		miso = sh[7];
	end
	// A released line must not keep its last bit, or a late sample would still match.
	always @(posedge cs_n) miso = ~miso;
endmodule

// ===== test/spie_ctrl_test.sv
// Self-checking bench for the SPI controller with its quirks.
`timescale 1ns/1ns
module spie_ctrl_test;
	logic ref_clk, rst, enable_cmd, disable_cmd, soft_reset_bit, mode_wr, cs_cfg_wr, tx_data_wr, rx_data_rd;
	logic miso_in, tx_empty_flag, rx_full_flag, enabled, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
	logic mosi_in, sck_in, nss_in;
	logic [7:0] b, echo;
	logic [1:0] cs_cfg_idx;
	logic [7:0] tx_data_reg, rx_data, reply, got, d;
	logic [3:0] cs_n_out;
	logic [31:0] seed = 32'h23da_970b;
	spie_pkg::spie_mode_t mode_wdata;
	spie_pkg::spie_cs_cfg_t cs_cfg_wdata;
	int n_fail, total_checks, falls;
	spie_ctrl dut (.ref_clk(ref_clk), .rst(rst), .enable_cmd(enable_cmd), .disable_cmd(disable_cmd),
		.soft_reset_bit(soft_reset_bit), .mode_wr(mode_wr), .mode_wdata(mode_wdata), .cs_cfg_wr(cs_cfg_wr),
		.cs_cfg_idx(cs_cfg_idx), .cs_cfg_wdata(cs_cfg_wdata), .tx_data_wr(tx_data_wr), .tx_data_reg(tx_data_reg),
		.rx_data_rd(rx_data_rd), .miso_in(miso_in), .mosi_in(mosi_in), .sck_in(sck_in), .nss_in(nss_in),
		.tx_empty_flag(tx_empty_flag), .rx_full_flag(rx_full_flag), .rx_data(rx_data), .enabled(enabled),
		.sck_out(sck_out), .sck_oe(sck_oe), .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_out(miso_out),
		.miso_oe(miso_oe), .cs_n_out(cs_n_out));
	spie_slave_model peer (.sck(sck_out), .cs_n(&cs_n_out), .mosi(mosi_out), .reply(reply), .miso(miso_in),
		.got(got));
	initial begin
		ref_clk = 0;
		forever #2 ref_clk = ~ref_clk;
	end
	always @(negedge sck_out) if (cs_n_out != 4'hf) falls++;
	function automatic logic [7:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, seen);
		end
	endtask
	task automatic step(int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic pulse(ref logic s);
		s = 1;
		step(1);
		s = 0;
		// The idle cycle keeps two pulses on one strobe from merging in one time step.
		step(1);
	endtask
	task automatic cfg(logic [1:0] i, logic [7:0] dv, logic pol, logic pha, logic hold);
		cs_cfg_idx = i;
		cs_cfg_wdata = '{dv, pol, pha, hold};
		pulse(cs_cfg_wr);
	endtask
	task automatic mode(logic m, logic fdd, logic [1:0] sel);
		mode_wdata = '{m, fdd, sel};
		pulse(mode_wr);
	endtask
	task automatic done(logic cmp);
		int k;
		for (k = 0; k < 3000 && rx_full_flag !== 1'b1; k++) step(1);
		chk("rx_full", rx_full_flag, 1);
		if (cmp) chk("rx_data", rx_data, reply);
		if (cmp) chk("peer_got", got, d);
		pulse(rx_data_rd);
		step(2);
	endtask
	task automatic xfer(logic cmp);
		d = xs();
		reply = xs();
		tx_data_reg = d;
		pulse(tx_data_wr);
		done(cmp);
	endtask
	task automatic sbyte(logic [7:0] v, output logic [7:0] echo_v);
		for (int i = 7; i >= 0; i--) begin
			mosi_in = v[i];
			sck_in = 1;
			step(1);
			echo_v[i] = miso_out;
			sck_in = 0;
			step(1);
		end
	endtask
	task automatic summarize();
		$display("checks %0d, mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#200000;
		n_fail++;
		summarize();
	end
	initial begin
		{rst, enable_cmd, disable_cmd, soft_reset_bit, mode_wr, cs_cfg_wr, tx_data_wr, rx_data_rd} = 8'h80;
		{cs_cfg_idx, tx_data_reg, reply, mode_wdata, cs_cfg_wdata, mosi_in, sck_in} = '0;
		nss_in = 1;
		step(4);
		rst = 0;
		chk("tx_empty", tx_empty_flag, 1);
		chk("cs_n", cs_n_out, 8'h0f);
		pulse(tx_data_wr);
		step(1);
		chk("tx_empty", tx_empty_flag, 1);
		mode(1, 0, 0);
		cfg(0, 8'h01, 0, 1, 1);
		pulse(enable_cmd);
		chk("sck_oe", sck_oe, 1);
		chk("mosi_oe", mosi_oe, 1);
		pulse(tx_data_wr);
		step(40);
		chk("cs_n", cs_n_out, 8'h0f);
		chk("tx_empty", tx_empty_flag, 0);
		mode(1, 1, 0);
		done(0);
		cfg(0, 8'h01, 0, 1, 0);
		step(4);
		chk("cs_n", cs_n_out, 8'h0f);
		for (int i = 0; i < 4; i++) begin
			cfg(0, 8'h01 + (xs() & 8'h03), 0, 1, 0);
			xfer(1);
		end
		cfg(0, 8'h01, 1, 0, 0);
		cfg(1, 8'h02, 1, 0, 0);
		mode(1, 1, 1);
		falls = 0;
		xfer(0);
		chk("sck_falls", falls, 9);
		mode(1, 1, 0);
		falls = 0;
		xfer(0);
		chk("sck_falls", falls, 8);
		cfg(1, 8'h01, 1, 0, 0);
		mode(1, 1, 1);
		falls = 0;
		xfer(0);
		chk("sck_falls", falls, 8);
		cfg(0, 8'h01, 0, 1, 1);
		mode(1, 0, 0);
		tx_data_wr = 1;
		repeat (3) begin
			d = xs();
			tx_data_reg = d;
			step(1);
		end
		tx_data_wr = 0;
		step(2);
		pulse(disable_cmd);
		chk("enabled", enabled, 0);
		chk("tx_empty", tx_empty_flag, 0);
		tx_data_reg = ~d;
		pulse(tx_data_wr);
		chk("tx_empty", tx_empty_flag, 0);
		cfg(0, 8'h01, 0, 1, 0);
		reply = xs();
		pulse(enable_cmd);
		done(1);
		mode(0, 1, 0);
		nss_in = 0;
		b = xs();
		sbyte(b, echo);
		chk("rx_full", rx_full_flag, 1);
		chk("rx_data", rx_data, b);
		chk("miso_oe", miso_oe, 1);
		chk("sck_oe", sck_oe, 0);
		pulse(rx_data_rd);
		pulse(disable_cmd);
		chk("enabled", enabled, 1);
		d = xs();
		sbyte(d, echo);
		chk("rx_data", rx_data, d);
		chk("miso_out", echo, b);
		pulse(rx_data_rd);
		chk("rx_full", rx_full_flag, 0);
		nss_in = 1;
		pulse(soft_reset_bit);
		chk("enabled", enabled, 0);
		chk("tx_empty", tx_empty_flag, 1);
		chk("rx_full", rx_full_flag, 0);
		chk("rx_data", rx_data, 0);
		chk("cs_n", cs_n_out, 8'h0f);
		chk("miso_oe", miso_oe, 0);
		chk("sck_oe", sck_oe, 0);
		summarize();
	end
endmodule
